// File: floppy_host_control_status_regs.v
// host byte-bus registers of the floppy controller: drive/motor control, tape/media, status
//
// Overview of operation
// RL1: output control register clears on hardware reset only; writable any time.
// RL2: two-bit drive select decodes to four one-hot select outputs.
// RL3: writing zero to reset bit holds controller in reset until one written.
// RL4: software reset keeps rate, config and other output bits; clears command settings.
// RL5: host keeps reset bit low at least 100 ns; back-to-back writes suffice.
// RL6: legacy mode: dma bit gates request, acknowledge, count and interrupt pins.
// RL7: enhanced mode: dma bit reads zero, dma and interrupt pins always enabled.
// RL8: bits 7..4 drive the four motor outputs; drives 2,3 decoded externally (here selects 2,3 are decoded inside the block).
// RL9: host should set motor and select together for each drive.
// RL10: compatible tape mode implements only tape select; bits 7..2 float on reads.
// RL11: config bit 6 selects enhanced tape mode; id ones, swap and tape zero.
// RL12: tape select names no drive or drive 1..3; drive 0 never tape.
// RL13: swap 00 none, 01 exchanges 0 and 1, 10 routes 2 to 0, 11 reserved.
// RL14: enhanced tape bits 5,4 return configured drive id.
// RL15: media bits 7,6 reflect media sense pins.
// RL16: status reads zero after reset, then request set within settle time.
// RL17: host reads status before each data byte except under dma.
// RL18: per-drive busy sets after seek command, clears on sense interrupt result read.
// RL19: command active sets on first command byte, clears at command end.
// RL20: non-dma execution bit shows programmed-transfer execution phase.
// RL21: direction bit is 0 for host write, 1 for host read.
// RL22: request clears after each byte, sets when ready; mirrors interrupt in execution.
// RL23: legacy or enhanced mode follows config bit 6; legacy is default.
// RL24: register writes reach select, motor and swap outputs next cycle.
`default_nettype none
`include "floppy_regs_defs.vh"

module floppy_host_control_status_regs #(
   parameter READY_CYC = `MST_READY_CYC,
   parameter SWRST_CYC = `SWRST_MIN_CYC
) (
   input  wire       sys_clk,
   input  wire       reset,
   // host byte bus
   input  wire [2:0] bus_addr,
   input  wire       bus_sel,
   input  wire       bus_rd,
   input  wire       bus_wr,
   input  wire [7:0] bus_wdata,
   output reg  [7:0] bus_rdata,
   output reg  [7:0] bus_rdata_oe,
   output reg        bus_rvalid,
   // configuration and media inputs
   input  wire       cfg_enhanced,
   input  wire [1:0] cfg_drive_id,
   input  wire       media_sense_in_0,
   input  wire       media_sense_in_1,
   // command engine events
   input  wire       cmd_first_byte,
   input  wire       cmd_last_no_result,
   input  wire       result_last_byte,
   input  wire       seek_cmd_done,
   input  wire [1:0] seek_drive,
   input  wire       sense_result_read,
   input  wire [1:0] sense_drive,
   input  wire       exec_nondma,
   input  wire       dir_to_host,
   input  wire       byte_done,
   input  wire       byte_ready,
   // dma and interrupt from engine, gated to pins
   input  wire       drq_in,
   input  wire       irq_in,
   input  wire       dack_n_in,
   input  wire       tc_in,
   output wire       drq_out,
   output wire       drq_oe,
   output wire       irq_out,
   output wire       irq_oe,
   output wire       dack_n_gated,
   output wire       tc_gated,
   // drive interface
   output wire       drive_select_out_0,
   output wire       drive_select_out_1,
   output wire       drive_select_out_2,
   output wire       drive_select_out_3,
   output wire       motor_on_0,
   output wire       motor_on_1,
   output wire       motor_on_2,
   output wire       motor_on_3,
   output wire [1:0] tape_drive_sel,
   output wire       ctrl_reset_out
);

   reg  [7:0] dmc_q;
   reg  [1:0] tape_sel_q;
   reg  [1:0] swap_q;
   reg  [1:0] rst_hold_q;
   reg  [7:0] rdata_d;
   reg  [7:0] roe_d;
   reg  [3:0] sel_int;
   reg  [3:0] sel_pin;
   reg  [3:0] mtr_pin;
   wire [3:0] mtr_int;
   wire [1:0] swap_eff;
   wire       enhanced;
   wire       wr_dmc;
   wire       wr_tmd;
   wire       rd_take;
   wire       dma_en;
   wire       ctrl_in_reset;
   wire [7:0] status_byte;
   wire [7:0] dmc_view;
   wire [7:0] tmd_view;

   assign enhanced = cfg_enhanced;                                  // [RL23]
   assign wr_dmc   = bus_sel & bus_wr & (bus_addr == `OFS_DRIVE_MOTOR);
   assign wr_tmd   = bus_sel & bus_wr & (bus_addr == `OFS_TAPE_MEDIA);
   assign rd_take  = bus_sel & bus_rd;

   // output control register: only hardware reset clears it
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dmc_q <= `DMC_RESET_VAL;                                   // [RL1]
      end else if (wr_dmc) begin
         dmc_q <= bus_wdata;                                        // [RL1] [RL24]
      end
   end

   // stretch a short zero pulse on the reset bit to the minimum hold
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rst_hold_q <= 2'h0;
      end else if (!dmc_q[`DMC_RESET_BIT]) begin
         rst_hold_q <= SWRST_CYC[1:0];                              // [RL5]
      end else if (rst_hold_q != 2'h0) begin
         rst_hold_q <= rst_hold_q - 2'h1;
      end
   end

   // controller held in reset while the bit is zero; register bank itself unaffected
   assign ctrl_in_reset  = ~dmc_q[`DMC_RESET_BIT] | (rst_hold_q != 2'h0);   // [RL3] [RL4]
   assign ctrl_reset_out = ctrl_in_reset;                                   // [RL4]

   // tape register: software reset leaves it alone, as with the other bank registers
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         tape_sel_q <= `TMD_TSEL_RESET;                             // [RL12] [RL11]
         swap_q     <= `TMD_SWAP_RESET;                             // [RL11]
      end else if (wr_tmd) begin
         tape_sel_q <= bus_wdata[`TMD_TSEL_HI:`TMD_TSEL_LO];        // [RL24]
         if (enhanced) begin
            swap_q <= bus_wdata[`TMD_SWAP_HI:`TMD_SWAP_LO];         // [RL11] [RL24]
         end
      end
   end

   // code 00 selects no tape drive; 01..11 name drives 1..3, never drive 0
   assign tape_drive_sel = tape_sel_q;                              // [RL12]

   // swap only acts in enhanced mode, where its bits exist
   assign swap_eff = enhanced ? swap_q : `SWAP_NONE;                // [RL11]

   always @* begin
      sel_int = 4'h0;
      sel_int[dmc_q[`DMC_DSEL_HI:`DMC_DSEL_LO]] = 1'b1;            // [RL2]
   end

   assign mtr_int = dmc_q[`DMC_MOTOR_HI:`DMC_MOTOR_LO];             // [RL8]

   // logical drive exchange onto the pin side
   always @* begin
      sel_pin = sel_int;
      mtr_pin = mtr_int;
      case (swap_eff)
         `SWAP_0_1: begin
            sel_pin[0] = sel_int[1];                                // [RL13]
            sel_pin[1] = sel_int[0];
            mtr_pin[0] = mtr_int[1];
            mtr_pin[1] = mtr_int[0];
         end
         `SWAP_0_2: begin
            sel_pin[0] = sel_int[2];                                // [RL13]
            sel_pin[2] = sel_int[0];
            mtr_pin[0] = mtr_int[2];
            mtr_pin[2] = mtr_int[0];
         end
         default: begin
            sel_pin = sel_int;                                      // [RL13]
            mtr_pin = mtr_int;
         end
      endcase
   end

   assign drive_select_out_0 = sel_pin[0];                          // [RL24]
   assign drive_select_out_1 = sel_pin[1];
   assign drive_select_out_2 = sel_pin[2];                          // [RL8]
   assign drive_select_out_3 = sel_pin[3];
   assign motor_on_0         = mtr_pin[0];                          // [RL8]
   assign motor_on_1         = mtr_pin[1];
   assign motor_on_2         = mtr_pin[2];
   assign motor_on_3         = mtr_pin[3];

   // pin gating: legacy follows the dma bit, enhanced keeps pins live even in reset
   assign dma_en       = enhanced | dmc_q[`DMC_DMA_BIT];            // [RL6] [RL7]
   assign drq_out      = drq_in;
   assign drq_oe       = dma_en;                                    // [RL6]
   assign irq_out      = irq_in;
   assign irq_oe       = dma_en;                                    // [RL6]
   assign dack_n_gated = dma_en ? dack_n_in : 1'b1;                 // [RL6]
   assign tc_gated     = dma_en & tc_in;                            // [RL6]

   main_status_tracker #(
      .DRIVES    (4),
      .READY_CYC (READY_CYC)
   ) u_status (
      .sys_clk            (sys_clk),
      .reset              (reset),
      .ctrl_in_reset      (ctrl_in_reset),
      .cmd_first_byte     (cmd_first_byte),
      .cmd_last_no_result (cmd_last_no_result),
      .result_last_byte   (result_last_byte),
      .seek_cmd_done      (seek_cmd_done),
      .seek_drive         (seek_drive),
      .sense_result_read  (sense_result_read),
      .sense_drive        (sense_drive),
      .exec_nondma        (exec_nondma),
      .dir_to_host        (dir_to_host),
      .byte_done          (byte_done),
      .byte_ready         (byte_ready),
      .irq_level          (irq_in),
      .status_byte        (status_byte)
   );

   // dma bit reads as zero in enhanced mode
   assign dmc_view = enhanced ? (dmc_q & ~(8'h01 << `DMC_DMA_BIT)) : dmc_q;   // [RL7]

   assign tmd_view = {media_sense_in_1,                             // [RL15]
                      media_sense_in_0,                             // [RL15]
                      cfg_drive_id,                                 // [RL14]
                      swap_q,
                      tape_sel_q};

   // read mux: undriven lanes float so other devices on the bus may answer
   always @* begin
      rdata_d = 8'h00;
      roe_d   = 8'h00;
      case (bus_addr)
         `OFS_DRIVE_MOTOR: begin
            rdata_d = dmc_view;
            roe_d   = 8'hff;
         end
         `OFS_TAPE_MEDIA: begin
            if (enhanced) begin
               rdata_d = tmd_view;                                  // [RL11]
               roe_d   = 8'hff;
            end else begin
               rdata_d = {6'h00, tape_sel_q};
               roe_d   = 8'h03;                                     // [RL10]
            end
         end
         `OFS_MAIN_STATUS: begin
            rdata_d = status_byte;                                  // [RL16]
            roe_d   = 8'hff;
         end
         default: begin
            rdata_d = 8'h00;
            roe_d   = 8'h00;
         end
      endcase
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         bus_rdata    <= 8'h00;
         bus_rdata_oe <= 8'h00;
         bus_rvalid   <= 1'b0;
      end else begin
         bus_rvalid <= rd_take;
         if (rd_take) begin
            bus_rdata    <= rdata_d;
            bus_rdata_oe <= roe_d;
         end else begin
            bus_rdata    <= 8'h00;
            bus_rdata_oe <= 8'h00;
         end
      end
   end

endmodule
`default_nettype wire

// File: floppy_regs_chk_sva.sv
// concurrent checks on the floppy host register block ports
`default_nettype none
`include "floppy_regs_defs.vh"
module floppy_regs_chk #(
   parameter SWRST_CYC = 3
) (
   input wire logic       sys_clk,
   input wire logic       reset,
   input wire logic [2:0] bus_addr,
   input wire logic       bus_sel,
   input wire logic       bus_rd,
   input wire logic       bus_wr,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   input wire logic [7:0] bus_rdata_oe,
   input wire logic       bus_rvalid,
   input wire logic       cfg_enhanced,
   input wire logic [1:0] cfg_drive_id,
   input wire logic       media_sense_in_0,
   input wire logic       media_sense_in_1,
   input wire logic       drq_oe,
   input wire logic       irq_oe,
   input wire logic       dack_n_gated,
   input wire logic       tc_gated,
   input wire logic       drive_select_out_0,
   input wire logic       drive_select_out_1,
   input wire logic       drive_select_out_2,
   input wire logic       drive_select_out_3,
   input wire logic       motor_on_0,
   input wire logic       ctrl_reset_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire logic wr_ctl = bus_sel && bus_wr && bus_addr == `OFS_DRIVE_MOTOR;
   wire logic rd_any = bus_sel && bus_rd;
   wire logic rd_tape = rd_any && bus_addr == `OFS_TAPE_MEDIA;

   a_sel_onehot: assert property (
      $onehot({drive_select_out_3, drive_select_out_2, drive_select_out_1, drive_select_out_0}))
      else $error("drive selects not one-hot");
   a_hw_clear: assert property ($fell(reset) |->
      drive_select_out_0 && !motor_on_0 && ctrl_reset_out) else $error("bad state after reset");
   a_write_route: assert property (wr_ctl && !cfg_enhanced |=> cfg_enhanced ||
      (drive_select_out_1 == ($past(bus_wdata[1:0]) == 2'h1) && motor_on_0 == $past(bus_wdata[4])))
      else $error("select or motor not updated after write");
   a_swrst_enter: assert property (wr_ctl && !bus_wdata[2] |=> ctrl_reset_out)
      else $error("controller not held in reset");
   a_swrst_hold: assert property ($fell(ctrl_reset_out) |-> $past(ctrl_reset_out, SWRST_CYC))
      else $error("controller reset too short");
   a_dma_legacy: assert property (wr_ctl && !cfg_enhanced |=> cfg_enhanced ||
      (drq_oe == $past(bus_wdata[3]) && irq_oe == drq_oe)) else $error("dma gate wrong");
   a_enh_pins: assert property (cfg_enhanced |-> drq_oe && irq_oe)
      else $error("pins not enabled in enhanced mode");
   a_gate_off: assert property (!drq_oe |-> dack_n_gated && !tc_gated)
      else $error("acknowledge or count not ignored");
   a_read_answer: assert property (bus_rvalid == $past(rd_any))
      else $error("read answer not one cycle after strobe");
   a_status_oe: assert property (rd_any && bus_addr == `OFS_MAIN_STATUS |=>
      bus_rdata_oe == 8'hff) else $error("status read not driven");
   a_status_zero: assert property (rd_any && bus_addr == `OFS_MAIN_STATUS && ctrl_reset_out
      |=> bus_rdata == 8'h00) else $error("status not zero in reset");
   a_tape_float: assert property (rd_tape && !cfg_enhanced |=> bus_rdata_oe == 8'h03)
      else $error("legacy tape upper bits driven");
   a_tape_enh: assert property (rd_tape && cfg_enhanced |=> bus_rdata[7:4] ==
      $past({media_sense_in_1, media_sense_in_0, cfg_drive_id})) else $error("media or id wrong");
endmodule
bind floppy_host_control_status_regs floppy_regs_chk #(.SWRST_CYC(SWRST_CYC)) u_chk (
   .sys_clk, .reset, .bus_addr, .bus_sel, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata,
   .bus_rdata_oe, .bus_rvalid, .cfg_enhanced, .cfg_drive_id, .media_sense_in_0,
   .media_sense_in_1, .drq_oe, .irq_oe, .dack_n_gated, .tc_gated, .drive_select_out_0,
   .drive_select_out_1, .drive_select_out_2, .drive_select_out_3, .motor_on_0, .ctrl_reset_out
);
`default_nettype wire

// File: floppy_regs_defs.vh
// register offsets, field positions, reset values and timing for the floppy host registers
`ifndef FLOPPY_REGS_DEFS_VH
`define FLOPPY_REGS_DEFS_VH

// byte offsets on the three-bit host address
`define OFS_DRIVE_MOTOR   3'h2
`define OFS_TAPE_MEDIA    3'h3
`define OFS_MAIN_STATUS   3'h4

// drive_motor_output_control fields
`define DMC_DSEL_LO       0
`define DMC_DSEL_HI       1
`define DMC_RESET_BIT     2
`define DMC_DMA_BIT       3
`define DMC_MOTOR_LO      4
`define DMC_MOTOR_HI      7
`define DMC_RESET_VAL     8'h00

// tape_media_drive_type fields
`define TMD_TSEL_LO       0
`define TMD_TSEL_HI       1
`define TMD_SWAP_LO       2
`define TMD_SWAP_HI       3
`define TMD_TSEL_RESET    2'h0
`define TMD_SWAP_RESET    2'h0
`define SWAP_NONE         2'h0
`define SWAP_0_1          2'h1
`define SWAP_0_2          2'h2

// controller_main_status fields
`define MST_REQ_BIT       7
`define MST_DIR_BIT       6
`define MST_NDMA_BIT      5
`define MST_CMD_BIT       4
`define MST_RESET_VAL     8'h00

// timing, clock period in ns
`define CLK_PERIOD_NS     40
`define MST_READY_NS      2500
`define MST_READY_CYC     (`MST_READY_NS / `CLK_PERIOD_NS)
`define SWRST_MIN_NS      100
`define SWRST_MIN_CYC     ((`SWRST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: host_bus_model.sv
// host processor model driving the floppy register byte bus
`default_nettype none
module host_bus_model (
   input  wire logic       sys_clk,
   output var  logic [2:0] bus_addr,
   output var  logic       bus_sel,
   output var  logic       bus_rd,
   output var  logic       bus_wr,
   output var  logic [7:0] bus_wdata,
   input  wire logic [7:0] bus_rdata,
   input  wire logic [7:0] bus_rdata_oe,
   input  wire logic       bus_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      bus_addr = 3'h0;
      bus_sel = 1'b0;
      bus_rd = 1'b0;
      bus_wr = 1'b0;
      bus_wdata = 8'h00;
   end
   // writes come two cycles apart, so a zero then one pair holds reset long enough
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(negedge sys_clk);
      bus_addr = a;
      bus_wdata = v;
      bus_sel = 1'b1;
      bus_wr = 1'b1;
      @(negedge sys_clk);
      bus_sel = 1'b0;
      bus_wr = 1'b0;
      bus_wdata = ~v;
      bus_addr = ~a;
   endtask
   // reads one register, waiting for the answer strobe before sampling data
   task automatic rd(input logic [2:0] a, output logic [7:0] v, output logic [7:0] en);
      @(negedge sys_clk);
      bus_addr = a;
      bus_sel = 1'b1;
      bus_rd = 1'b1;
      @(negedge sys_clk);
      bus_sel = 1'b0;
      bus_rd = 1'b0;
      bus_addr = ~a;
      if (bus_rvalid !== 1'b1) @(negedge sys_clk);
      v = bus_rvalid === 1'b1 ? bus_rdata : 8'hxx;
      en = bus_rdata_oe;
   endtask
endmodule
`default_nettype wire

// File: main_status_tracker.v
// main status byte: ready delay after reset, request flag, command and per-drive busy flags
`default_nettype none
`include "floppy_regs_defs.vh"

module main_status_tracker #(
   parameter DRIVES = 4,
   parameter READY_CYC = `MST_READY_CYC
) (
   input  wire       sys_clk,
   input  wire       reset,
   input  wire       ctrl_in_reset,
   input  wire       cmd_first_byte,
   input  wire       cmd_last_no_result,
   input  wire       result_last_byte,
   input  wire       seek_cmd_done,
   input  wire [1:0] seek_drive,
   input  wire       sense_result_read,
   input  wire [1:0] sense_drive,
   input  wire       exec_nondma,
   input  wire       dir_to_host,
   input  wire       byte_done,
   input  wire       byte_ready,
   input  wire       irq_level,
   output wire [7:0] status_byte
);

   reg  [7:0]        init_cnt_q;
   reg               ready_q;
   reg               rqm_q;
   reg               cmd_q;
   reg  [DRIVES-1:0] busy_q;
   wire              host_transfer_request;
   wire              transfer_direction;
   wire              command_active;

   // settle timer: request, direction and non-dma bits read zero until it expires after any reset
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         init_cnt_q <= 8'h00;
         ready_q    <= 1'b0;
      end else if (ctrl_in_reset) begin
         init_cnt_q <= 8'h00;
         ready_q    <= 1'b0;
      end else if (!ready_q) begin
         if (init_cnt_q == READY_CYC[7:0] - 8'h01) begin
            ready_q <= 1'b1;                                     // [RL16]
         end
         init_cnt_q <= init_cnt_q + 8'h01;
      end
   end

   // request flag drops on each byte moved, rises when engine is ready; rise wins
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rqm_q <= 1'b0;
      end else if (ctrl_in_reset) begin
         rqm_q <= 1'b0;
      end else if (!ready_q) begin
         rqm_q <= (init_cnt_q == READY_CYC[7:0] - 8'h01);       // [RL16]
      end else if (byte_ready) begin
         rqm_q <= 1'b1;                                         // [RL22]
      end else if (byte_done) begin
         rqm_q <= 1'b0;                                         // [RL22]
      end
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cmd_q <= 1'b0;
      end else if (ctrl_in_reset) begin
         cmd_q <= 1'b0;
      end else if (cmd_first_byte) begin
         cmd_q <= 1'b1;                                         // [RL19]
      end else if (cmd_last_no_result || result_last_byte) begin
         cmd_q <= 1'b0;                                         // [RL19]
      end
   end

   genvar i;
   generate
      for (i = 0; i < DRIVES; i = i + 1) begin : g_busy
         always @(posedge sys_clk or posedge reset) begin
            if (reset) begin
               busy_q[i] <= 1'b0;
            end else if (ctrl_in_reset) begin
               busy_q[i] <= 1'b0;
            end else if (seek_cmd_done && seek_drive == i) begin
               busy_q[i] <= 1'b1;                               // [RL18]
            end else if (sense_result_read && sense_drive == i) begin
               busy_q[i] <= 1'b0;                               // [RL18]
            end
         end
      end
   endgenerate

   // during non-dma execution the request flag follows the interrupt line
   assign host_transfer_request = ready_q & (exec_nondma ? irq_level : rqm_q);   // [RL22]
   assign transfer_direction    = ready_q & dir_to_host;                         // [RL21]
   assign command_active        = cmd_q;

   assign status_byte = {host_transfer_request,
                         transfer_direction,
                         ready_q & exec_nondma,                                 // [RL20]
                         command_active,
                         busy_q};

endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the floppy host control and status registers
`default_nettype none
`include "floppy_regs_defs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
   $display("Error at %0t ns: got %h expected %h", $time, (g), (e)); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int READY = 8;
   logic       sys_clk = 1'b0;
   logic       reset = 1'b1;
   logic [2:0] bus_addr;
   logic       bus_sel, bus_rd, bus_wr, bus_rvalid;
   logic [7:0] bus_wdata, bus_rdata, bus_rdata_oe, d, oe;
   logic       cfg_enhanced = 1'b0;
   logic [1:0] cfg_drive_id = 2'h3, seek_drive = 2'h0, sense_drive = 2'h0, tape_drive_sel;
   logic       media_sense_in_0 = 1'b0, media_sense_in_1 = 1'b0, exec_nondma = 1'b0;
   logic       cmd_first_byte = 1'b0, cmd_last_no_result = 1'b0, result_last_byte = 1'b0;
   logic       seek_cmd_done = 1'b0, sense_result_read = 1'b0, dir_to_host = 1'b0;
   logic       byte_done = 1'b0, byte_ready = 1'b0, drq_in = 1'b0, irq_in = 1'b0;
   logic       dack_n_in = 1'b1, tc_in = 1'b0, drq_out, drq_oe, irq_out, irq_oe;
   logic       dack_n_gated, tc_gated, ctrl_reset_out, motor_on_0, motor_on_1;
   logic       motor_on_2, motor_on_3, drive_select_out_0, drive_select_out_1;
   logic       drive_select_out_2, drive_select_out_3;
   int         mismatches = 0;
   int         checks = 0;
   wire logic [3:0] sel_v = {drive_select_out_3, drive_select_out_2, drive_select_out_1,
                             drive_select_out_0};
   wire logic [3:0] mtr_v = {motor_on_3, motor_on_2, motor_on_1, motor_on_0};

   always #(`CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

   floppy_host_control_status_regs #(.READY_CYC(READY), .SWRST_CYC(3)) DUT (
      .sys_clk, .reset, .bus_addr, .bus_sel, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata,
      .bus_rdata_oe, .bus_rvalid, .cfg_enhanced, .cfg_drive_id, .media_sense_in_0,
      .media_sense_in_1, .cmd_first_byte, .cmd_last_no_result, .result_last_byte,
      .seek_cmd_done, .seek_drive, .sense_result_read, .sense_drive, .exec_nondma,
      .dir_to_host, .byte_done, .byte_ready, .drq_in, .irq_in, .dack_n_in, .tc_in, .drq_out,
      .drq_oe, .irq_out, .irq_oe, .dack_n_gated, .tc_gated, .drive_select_out_0,
      .drive_select_out_1, .drive_select_out_2, .drive_select_out_3, .motor_on_0,
      .motor_on_1, .motor_on_2, .motor_on_3, .tape_drive_sel, .ctrl_reset_out
   );
   host_bus_model H (.sys_clk, .bus_addr, .bus_sel, .bus_rd, .bus_wr, .bus_wdata, .bus_rdata,
      .bus_rdata_oe, .bus_rvalid);

   task automatic test_done;
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic pulse(ref logic s);
      @(negedge sys_clk);
      s = 1'b1;
      @(negedge sys_clk);
      s = 1'b0;
   endtask
   task automatic rs;
      H.rd(`OFS_MAIN_STATUS, d, oe);
   endtask
   task automatic poll;
      int n = 0;
      while (d !== 8'h80 && n < READY + 10) begin
         rs();
         n++;
      end
   endtask
   task automatic t_reset;
      `CHK({sel_v, mtr_v, ctrl_reset_out, drq_oe}, 10'h042)
      H.rd(`OFS_DRIVE_MOTOR, d, oe);
      `CHK(d, `DMC_RESET_VAL)
      rs();
      `CHK(d, `MST_RESET_VAL)
      cfg_enhanced = 1'b1;
      media_sense_in_0 = 1'b1;
      H.rd(`OFS_TAPE_MEDIA, d, oe);
      `CHK(d, 8'h70)
      cfg_enhanced = 1'b0;
      media_sense_in_0 = 1'b0;
   endtask
   task automatic t_settle;
      H.wr(`OFS_DRIVE_MOTOR, 8'h0c);
      rs();
      `CHK(d, 8'h00)
      poll();
      `CHK(d, 8'h80)
   endtask
   task automatic t_drives;
      logic [7:0] tbl [4] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f};
      for (int i = 0; i < 4; i++) begin
         H.wr(`OFS_DRIVE_MOTOR, tbl[i]);
         `CHK({sel_v, mtr_v}, {4'h1 << i, 4'h1 << i})
         H.rd(`OFS_DRIVE_MOTOR, d, oe);
         `CHK(d, tbl[i])
      end
   endtask
   task automatic t_status;
      pulse(cmd_first_byte);
      rs();
      `CHK(d, 8'h90)
      seek_drive = 2'h2;
      pulse(seek_cmd_done);
      sense_drive = 2'h1;
      pulse(sense_result_read);
      rs();
      `CHK(d, 8'h94)
      sense_drive = 2'h2;
      pulse(sense_result_read);
      pulse(cmd_last_no_result);
      rs();
      `CHK(d, 8'h80)
      dir_to_host = 1'b1;
      pulse(cmd_first_byte);
      rs();
      `CHK(d, 8'hd0)
      pulse(byte_done);
      rs();
      `CHK(d, 8'h50)
      pulse(byte_ready);
      exec_nondma = 1'b1;
      rs();
      `CHK(d, 8'h70)
      irq_in = 1'b1;
      rs();
      `CHK(d, 8'hf0)
      exec_nondma = 1'b0;
      irq_in = 1'b0;
      dir_to_host = 1'b0;
      pulse(result_last_byte);
      rs();
      `CHK(d, 8'h80)
   endtask
   task automatic t_swreset;
      pulse(cmd_first_byte);
      H.wr(`OFS_DRIVE_MOTOR, 8'h18);
      H.wr(`OFS_DRIVE_MOTOR, 8'h1c);
      `CHK({ctrl_reset_out, motor_on_0}, 2'b11)
      rs();
      `CHK(d, 8'h00)
      poll();
      `CHK(d, 8'h80)
      H.rd(`OFS_DRIVE_MOTOR, d, oe);
      `CHK(d, 8'h1c)
   endtask
   task automatic t_dma;
      dack_n_in = 1'b0;
      tc_in = 1'b1;
      drq_in = 1'b1;
      H.wr(`OFS_DRIVE_MOTOR, 8'h14);
      `CHK({drq_oe, irq_oe, dack_n_gated, tc_gated}, 4'b0010)
      H.wr(`OFS_DRIVE_MOTOR, 8'h1c);
      `CHK({drq_oe, irq_oe, drq_out, dack_n_gated, tc_gated}, 5'b11101)
      cfg_enhanced = 1'b1;
      H.wr(`OFS_DRIVE_MOTOR, 8'h14);
      `CHK({drq_oe, irq_oe}, 2'b11)
      H.wr(`OFS_DRIVE_MOTOR, 8'h1c);
      H.rd(`OFS_DRIVE_MOTOR, d, oe);
      `CHK(d, 8'h14)
      cfg_enhanced = 1'b0;
      dack_n_in = 1'b1;
      tc_in = 1'b0;
   endtask
   task automatic t_tape;
      H.wr(`OFS_TAPE_MEDIA, 8'h0e);
      H.rd(`OFS_TAPE_MEDIA, d, oe);
      `CHK({tape_drive_sel, oe, d[1:0]}, 12'h80e)
      H.rd(3'h6, d, oe);
      `CHK(oe, 8'h00)
      cfg_enhanced = 1'b1;
      cfg_drive_id = 2'h2;
      media_sense_in_1 = 1'b1;
      for (int t = 0; t < 4; t++) begin
         H.wr(`OFS_TAPE_MEDIA, 8'(t));
         `CHK(tape_drive_sel, 2'(t))
      end
      H.rd(`OFS_TAPE_MEDIA, d, oe);
      `CHK({oe, d}, 16'hffa3)
      H.wr(`OFS_TAPE_MEDIA, 8'h04);
      H.wr(`OFS_DRIVE_MOTOR, 8'h2d);
      `CHK({sel_v, mtr_v}, 8'h11)
      H.wr(`OFS_TAPE_MEDIA, 8'h08);
      H.wr(`OFS_DRIVE_MOTOR, 8'h4e);
      `CHK({sel_v, mtr_v}, 8'h11)
      H.wr(`OFS_TAPE_MEDIA, 8'h00);
      `CHK({sel_v, mtr_v}, 8'h44)
      cfg_enhanced = 1'b0;
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      reset = 1'b0;
      t_reset();
      t_settle();
      t_drives();
      t_status();
      t_swreset();
      t_dma();
      t_tape();
      test_done();
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      mismatches++;
      $display("Error at %0t ns: watchdog expired", $time);
      test_done();
   end
endmodule
`default_nettype wire
